// File: iops_pkg.sv
// constants and a helper function shared by the io stack event-select block
// assumes one clock (mclk) and a synchronous active-high reset
package iops_pkg;

   // ****************************************
   // event codes and limits
   // ****************************************
   localparam logic [7:0] EV_CLOCKTICK = 8'h81;
   localparam logic [7:0] EV_CB_INSERT = 8'hC2;
   localparam logic [7:0] EV_CB_OCC = 8'hD5;
   localparam logic [7:0] EV_DREQ = 8'hC0;
   localparam int TC_CLK_MHZ = 500;
   localparam int DWORD_BYTES = 4;
   localparam logic [10:0] DREQ_MAX_INC = 11'h400;
   localparam logic [3:0] CTRS_ALL = 4'hF;
   localparam logic [3:0] CTRS_HIGH = 4'hC;
   localparam int NUM_CTR = 4;
   localparam int NUM_PORT = 8;
   localparam int OCC_W = 8;
   localparam int INC_W = 11;
   localparam int CNT_W = 48;

   // ****************************************
   // unit mask, flow class and channel fields
   // ****************************************
   localparam int UM_MEM_WR = 0;
   localparam int UM_PEER_WR = 1;
   localparam int UM_MEM_RD = 2;
   localparam int UM_PEER_RD = 3;
   localparam int UM_CFG_WR = 4;
   localparam int FC_POSTED = 0;
   localparam int FC_NONPOSTED = 1;
   localparam int FC_CMPL = 2;
   localparam int CH_TU0 = 8;
   localparam int CH_TU1 = 9;
   localparam logic [3:0] TGT_LAST = 4'h9;

   // ****************************************
   // register map and field positions
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [1:0] REG_CTL = 2'h0;
   localparam logic [1:0] REG_FLT = 2'h1;
   localparam logic [1:0] REG_CNT_LO = 2'h2;
   localparam logic [1:0] REG_CNT_HI = 2'h3;
   localparam int CTL_EVT_LSB = 0;
   localparam int CTL_UM_LSB = 8;
   localparam int CTL_EN_BIT = 22;
   localparam int FLT_CH_LSB = 0;
   localparam int FLT_FC_LSB = 12;
   localparam logic [31:0] CTL_RST = 32'h0000_0000;
   localparam logic [31:0] FLT_RST = 32'h0000_0000;
   localparam logic [31:0] CTL_MASK = 32'h0040_FFFF;
   localparam logic [31:0] FLT_MASK = 32'h0000_7FFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // counters on which each event may run
   function automatic logic [3:0] ctr_allow(input logic [7:0] ev);
      logic [3:0] m;
      m = 4'h0;
      if (ev == EV_CLOCKTICK || ev == EV_CB_INSERT) begin
         m = CTRS_ALL;
      end else if (ev == EV_CB_OCC || ev == EV_DREQ) begin
         m = CTRS_HIGH;
      end
      return m;
   endfunction : ctr_allow

endpackage : iops_pkg

// File: iops_evt_if.sv
// bundle of traffic-controller event signals for the increment logic
// assumes all signals are on mclk
interface iops_evt_if;
   import iops_pkg::*;
   logic ins_vld;
   logic [2:0] ins_port;
   logic dreq_vld;
   logic dreq_write;
   logic dreq_peer;
   logic dreq_cfg;
   logic dreq_confined;
   logic [3:0] dreq_target;
   logic [INC_W-1:0] dreq_dwords;
   modport src (output ins_vld, ins_port, dreq_vld, dreq_write, dreq_peer,
      dreq_cfg, dreq_confined, dreq_target, dreq_dwords);
   modport sink (input ins_vld, ins_port, dreq_vld, dreq_write, dreq_peer,
      dreq_cfg, dreq_confined, dreq_target, dreq_dwords);
endinterface : iops_evt_if

// File: iops_occ_sum.sv
// sums completion-buffer occupancy over the ports a unit mask selects
// assumes occupancy levels are on mclk, packed port 0 lowest
module iops_occ_sum
   import iops_pkg::*;
(
   input wire logic [NUM_PORT-1:0] port_sel,
   input wire logic [NUM_PORT*OCC_W-1:0] occ_level,
   output logic [INC_W-1:0] occ_total
);
   always_comb begin
      occ_total = '0;
      for (int i = 0; i < NUM_PORT; i++) begin
         if (port_sel[i]) begin
            occ_total = occ_total + INC_W'(occ_level[i*OCC_W +: OCC_W]);
         end
      end
   end
endmodule : iops_occ_sum

// File: iops_inc_calc.sv
// per-counter increment selection for the four supported events
// assumes control words come from registers on the same clock
module iops_inc_calc
   import iops_pkg::*;
#(
   parameter int CTR_IDX = 0
) (
   iops_evt_if.sink evt,
   input wire logic [31:0] ctl,
   input wire logic [31:0] flt,
   input wire logic [INC_W-1:0] occ_total,
   output logic [INC_W-1:0] inc
);
   logic [7:0] ev;
   logic [7:0] um;
   logic [11:0] ch;
   logic [2:0] fc;
   logic [INC_W-1:0] raw;
   logic kind_hit;
   logic cls_hit;
   logic tgt_hit;
   logic [3:0] allow;

   assign ev = ctl[CTL_EVT_LSB +: 8];
   assign um = ctl[CTL_UM_LSB +: 8];
   assign ch = flt[FLT_CH_LSB +: 12];
   assign fc = flt[FLT_FC_LSB +: 3];
   assign allow = ctr_allow(ev);

   // data request qualification
   always_comb begin
      // no confined peers; peers also memory; umask bits
      kind_hit = (um[UM_MEM_WR] && evt.dreq_write && !evt.dreq_cfg)
         || (um[UM_PEER_WR] && evt.dreq_write && !evt.dreq_cfg
            && evt.dreq_peer && !evt.dreq_confined)
         || (um[UM_MEM_RD] && !evt.dreq_write)
         || (um[UM_PEER_RD] && !evt.dreq_write && evt.dreq_peer
            && !evt.dreq_confined)
         || (um[UM_CFG_WR] && evt.dreq_write && evt.dreq_cfg);
      cls_hit = (evt.dreq_write && !evt.dreq_cfg) ? fc[FC_POSTED]
         : fc[FC_NONPOSTED];
      tgt_hit = (evt.dreq_target <= TGT_LAST) && ch[evt.dreq_target];
   end

   // event select and increment
   always_comb begin
      raw = '0;
      case (ev)
         EV_CLOCKTICK: raw = INC_W'(1);
         EV_CB_INSERT: begin
            if (um[1:0] == 2'b11 && fc[FC_CMPL] && evt.ins_vld
               && ch[evt.ins_port]) begin
               raw = INC_W'(1);
            end
         end
         EV_CB_OCC: raw = fc[FC_CMPL] ? occ_total : '0;
         EV_DREQ: begin
            if (evt.dreq_vld && kind_hit && cls_hit && tgt_hit) begin
               raw = (evt.dreq_dwords > DREQ_MAX_INC) ? DREQ_MAX_INC
                  : evt.dreq_dwords;
            end
         end
         default: raw = '0;
      endcase
      inc = (ctl[CTL_EN_BIT] && allow[CTR_IDX]) ? raw : '0;
   end
endmodule : iops_inc_calc

// File: iops_top.sv
// io stack performance event select with four counters, axi4-lite slave
// assumes event inputs come from logic on mclk; no synchronisers needed
module iops_top
   import iops_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cb_insert_vld,
   input wire logic [2:0] cb_insert_port,
   input wire logic [NUM_PORT*OCC_W-1:0] cb_occ_level,
   input wire logic dreq_vld,
   input wire logic dreq_write,
   input wire logic dreq_peer,
   input wire logic dreq_cfg,
   input wire logic dreq_confined,
   input wire logic [3:0] dreq_target,
   input wire logic [INC_W-1:0] dreq_dwords,
   output logic [NUM_CTR-1:0] ctr_running
);

   // ****************************************
   // state of the block
   // ****************************************

   typedef struct packed {
      logic awrdy;
      logic wrdy;
      logic arrdy;
      logic aw_held;
      logic [ADDR_W-3:0] aw_idx;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [NUM_CTR-1:0] running;
      logic [NUM_CTR-1:0][31:0] ctl;
      logic [NUM_CTR-1:0][31:0] flt;
      logic [NUM_CTR-1:0][CNT_W-1:0] cnt;
   } iops_state_t;

   localparam iops_state_t ST_RST = '{
      awrdy: 1'b0,
      wrdy: 1'b0,
      arrdy: 1'b0,
      aw_held: 1'b0,
      aw_idx: '0,
      w_held: 1'b0,
      wdata: 32'h0000_0000,
      wstrb: 4'h0,
      bvalid: 1'b0,
      bresp: RESP_OKAY,
      rvalid: 1'b0,
      rdata: 32'h0000_0000,
      rresp: RESP_OKAY,
      running: '0,
      ctl: {NUM_CTR{CTL_RST}},
      flt: {NUM_CTR{FLT_RST}},
      cnt: '0
   };

   iops_state_t st_q;
   iops_state_t st_d;
   logic [NUM_CTR-1:0][INC_W-1:0] inc;
   logic [NUM_CTR-1:0][INC_W-1:0] occ_total;

   // ****************************************
   // helper functions
   // ****************************************

   // merge write data into a word by byte strobes, keeping writable bits
   function automatic logic [31:0] merge_word(
      input logic [31:0] old_w,
      input logic [31:0] new_w,
      input logic [3:0] strb,
      input logic [31:0] wmask
   );
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return r & wmask;
   endfunction : merge_word

   // true when the counter number of a word index lies inside the map
   function automatic logic idx_hit(input logic [ADDR_W-3:0] idx);
      return int'(idx[ADDR_W-3:2]) < NUM_CTR;
   endfunction : idx_hit

   // ****************************************
   // event bundle and increment logic
   // ****************************************

   iops_evt_if evt ();

   // event inputs share mclk, so they feed the increment logic directly
   assign evt.ins_vld = cb_insert_vld;
   assign evt.ins_port = cb_insert_port;
   assign evt.dreq_vld = dreq_vld;
   assign evt.dreq_write = dreq_write;
   assign evt.dreq_peer = dreq_peer;
   assign evt.dreq_cfg = dreq_cfg;
   assign evt.dreq_confined = dreq_confined;
   assign evt.dreq_target = dreq_target;
   assign evt.dreq_dwords = dreq_dwords;

   // one occupancy adder and one selector per counter
   for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
      iops_occ_sum u_occ (
         .port_sel (st_q.ctl[g][CTL_UM_LSB +: NUM_PORT]),
         .occ_level (cb_occ_level),
         .occ_total (occ_total[g])
      );
      iops_inc_calc #(
         .CTR_IDX (g)
      ) u_inc (
         .evt (evt),
         .ctl (st_q.ctl[g]),
         .flt (st_q.flt[g]),
         .occ_total (occ_total[g]),
         .inc (inc[g])
      );
   end

   // ****************************************
   // next-state logic
   // ****************************************

   always_comb begin
      logic [ADDR_W-3:0] ridx;
      logic [1:0] rsel;
      logic [1:0] wsel;
      int rn;
      int wn;
      logic [3:0] alw;
      st_d = st_q;
      alw = 4'h0;
      ridx = s_axi_araddr[ADDR_W-1:2];
      rsel = ridx[1:0];
      wsel = st_q.aw_idx[1:0];
      rn = int'(ridx[ADDR_W-3:2]);
      wn = int'(st_q.aw_idx[ADDR_W-3:2]);

      // counters add their selected increment every clock
      for (int i = 0; i < NUM_CTR; i++) begin
         st_d.cnt[i] = st_q.cnt[i] + CNT_W'(inc[i]);
         // allowed-counter mask of this counter's event code
         alw = ctr_allow(st_q.ctl[i][CTL_EVT_LSB +: 8]);
         st_d.running[i] = st_q.ctl[i][CTL_EN_BIT] && alw[i];
      end

      // write address and data are taken independently
      if (s_axi_awvalid && st_q.awrdy) begin
         st_d.aw_held = 1'b1;
         st_d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && st_q.wrdy) begin
         st_d.w_held = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      // commit a write once both halves are held
      if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = RESP_OKAY;
         if (!idx_hit(st_q.aw_idx)) begin
            st_d.bresp = RESP_SLVERR;
         end else if (wsel == REG_CTL) begin
            st_d.ctl[wn] = merge_word(st_q.ctl[wn], st_q.wdata,
               st_q.wstrb, CTL_MASK);
         end else if (wsel == REG_FLT) begin
            st_d.flt[wn] = merge_word(st_q.flt[wn], st_q.wdata,
               st_q.wstrb, FLT_MASK);
         end else if (wsel == REG_CNT_LO) begin
            // any write to the low word clears the whole counter
            st_d.cnt[wn] = '0;
         end
      end

      // read channel, answer one cycle after the address is taken
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_q.arrdy) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = RESP_OKAY;
         st_d.rdata = 32'h0000_0000;
         if (!idx_hit(ridx)) begin
            st_d.rresp = RESP_SLVERR;
         end else if (rsel == REG_CTL) begin
            st_d.rdata = st_q.ctl[rn];
         end else if (rsel == REG_FLT) begin
            st_d.rdata = st_q.flt[rn];
         end else if (rsel == REG_CNT_LO) begin
            st_d.rdata = st_q.cnt[rn][31:0];
         end else begin
            st_d.rdata = {16'h0000, st_q.cnt[rn][CNT_W-1:32]};
         end
      end

      // ready flags follow what is held after this edge
      st_d.awrdy = !st_d.aw_held && !st_d.bvalid;
      st_d.wrdy = !st_d.w_held && !st_d.bvalid;
      st_d.arrdy = !st_d.rvalid;
   end

   // ****************************************
   // state register
   // ****************************************

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // outputs, all straight from the state register
   // ****************************************

   assign s_axi_awready = st_q.awrdy;
   assign s_axi_wready = st_q.wrdy;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arrdy;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign ctr_running = st_q.running;

endmodule : iops_top

// File: iops_top_sva.sv
// checker for the event-select block, watching only its top-level ports
// assumes one mclk domain, synchronous active-high sys_rst, full strobes
module iops_top_sva
   import iops_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_CTR-1:0] ctr_running
);
   logic [8:0] ctl_q [NUM_CTR];
   logic [3:0] want;
   logic [3:0] w1_q;
   logic [3:0] w2_q;
   logic wr_hs;
   logic ar_hs;

   // address and data taken together at one edge
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;

   // run flags expected from the shadowed control words
   always_comb begin
      for (int i = 0; i < NUM_CTR; i++) begin
         want[i] = ctl_q[i][8] && (ctl_q[i][7:0] == EV_CLOCKTICK ||
            ctl_q[i][7:0] == EV_CB_INSERT || (i >= 2 &&
            (ctl_q[i][7:0] == EV_CB_OCC || ctl_q[i][7:0] == EV_DREQ)));
      end
   end

   // shadow enable and code of each control word; delay flags two edges
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctl_q <= '{default: '0};
         w1_q <= '0;
         w2_q <= '0;
      end else begin
         if (wr_hs && s_axi_awaddr[7:6] == 2'h0 &&
            s_axi_awaddr[3:2] == 2'h0) begin
            ctl_q[s_axi_awaddr[5:4]] <= {s_axi_wdata[22], s_axi_wdata[7:0]};
         end
         w1_q <= want;
         w2_q <= w1_q;
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_run_flags: assert property (ctr_running == w2_q)
      else $error("run flags disagree with control words");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_rd_answer: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_bad_read: assert property (ar_hs && s_axi_araddr >= 8'h40 |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_bad_write: assert property (wr_hs && s_axi_awaddr >= 8'h40 |->
      ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_good_write: assert property (wr_hs && s_axi_awaddr < 8'h40 |->
      ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("mapped write answer wrong");
   a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
endmodule : iops_top_sva

bind iops_top iops_top_sva u_iops_top_sva (
   .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .ctr_running
);

// File: iops_tc_model.sv
// traffic-controller stand-in driving insert, occupancy and request events
// assumes the bench calls its tasks; every change follows a rising mclk
module iops_tc_model
   import iops_pkg::*;
(
   input wire logic mclk,
   output logic cb_insert_vld,
   output logic [2:0] cb_insert_port,
   output logic [NUM_PORT*OCC_W-1:0] cb_occ_level,
   output logic dreq_vld,
   output logic dreq_write,
   output logic dreq_peer,
   output logic dreq_cfg,
   output logic dreq_confined,
   output logic [3:0] dreq_target,
   output logic [INC_W-1:0] dreq_dwords
);
   // idle levels at time zero
   initial begin
      cb_insert_vld = 1'b0;
      cb_insert_port = 3'h0;
      cb_occ_level = '0;
      dreq_vld = 1'b0;
      {dreq_write, dreq_peer, dreq_cfg, dreq_confined} = 4'h0;
      dreq_target = 4'hF;
      dreq_dwords = 11'h0;
   end

   // one insert pulse; the port field shows junk once idle
   task automatic ins(input logic [2:0] p);
      @(posedge mclk);
      cb_insert_vld <= 1'b1;
      cb_insert_port <= p;
      @(posedge mclk);
      cb_insert_vld <= 1'b0;
      cb_insert_port <= ~p;
   endtask : ins

   // occupancy levels, port 0 in the low byte
   task automatic occ(input logic [NUM_PORT*OCC_W-1:0] lvl);
      @(posedge mclk);
      cb_occ_level <= lvl;
   endtask : occ

   // one request; kind is write, peer, config, confined
   task automatic req(input logic [18:0] r);
      @(posedge mclk);
      dreq_vld <= 1'b1;
      {dreq_write, dreq_peer, dreq_cfg, dreq_confined} <= r[18:15];
      dreq_target <= r[14:11];
      dreq_dwords <= r[10:0];
      @(posedge mclk);
      dreq_vld <= 1'b0;
      {dreq_write, dreq_peer, dreq_cfg, dreq_confined} <= ~r[18:15];
      dreq_target <= ~r[14:11];
      dreq_dwords <= ~r[10:0];
   endtask : req
endmodule : iops_tc_model

// File: io_stack_perf_event_select_test.sv
// self-checking bench for the io stack event-select block
// assumes iops_top, iops_tc_model and the bound checker are compiled
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   err_total++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module io_stack_perf_event_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   import iops_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hF, dreq_target, ctr_running;
   logic [31:0] s_axi_wdata, s_axi_rdata, a, b;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, cb_insert_vld, dreq_vld, dreq_write;
   logic dreq_peer, dreq_cfg, dreq_confined;
   logic [2:0] cb_insert_port;
   logic [63:0] cb_occ_level;
   logic [10:0] dreq_dwords;
   int ca, cb, cyc = 0, err_total = 0, total_checks = 0;

   iops_top u_iops_top (
      .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cb_insert_vld, .cb_insert_port, .cb_occ_level, .dreq_vld,
      .dreq_write, .dreq_peer, .dreq_cfg, .dreq_confined, .dreq_target,
      .dreq_dwords, .ctr_running
   );
   iops_tc_model u_iops_tc_model (
      .mclk, .cb_insert_vld, .cb_insert_port, .cb_occ_level, .dreq_vld,
      .dreq_write, .dreq_peer, .dreq_cfg, .dreq_confined, .dreq_target,
      .dreq_dwords
   );

   always #12.5 mclk = ~mclk;

   // cycle count and hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         give_verdict();
      end
   end

   // ****************************************
   // bus tasks
   // ****************************************
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         ta = ta || s_axi_awready === 1'b1;
         tw = tw || s_axi_wready === 1'b1;
      end
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] d,
      output int c);
      @(posedge mclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      c = cyc;
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      for (int i = 0; i < 16; i++) begin
         rd(8'(i * 4), a, ca);
         `CHK("reset value", 32'h0, a)
      end
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, a, ca);
      `CHK("control mask", 32'h0040_FFFF, a)
      wr(8'h10, 32'h0);
      wr(8'h44, 32'h1);
      `CHK("bad write", RESP_SLVERR, resp)
      rd(8'h40, a, ca);
      `CHK("bad read", {RESP_SLVERR, 32'h0}, {resp, a})
      $display("t_regs done");
   endtask : t_regs

   task automatic t_restrict();
      logic [7:0] ev [4] = '{EV_CLOCKTICK, EV_CB_INSERT, EV_CB_OCC, EV_DREQ};
      logic ok;
      for (int k = 0; k < 16; k++) begin
         wr(8'(k % 4 * 16), {24'h004000, ev[k / 4]});
         repeat (3) @(posedge mclk);
         ok = k < 8 || k % 4 >= 2;
         `CHK("allowed", ok, ctr_running[k % 4])
         wr(8'(k % 4 * 16), 32'h0);
      end
      $display("t_restrict done");
   endtask : t_restrict

   task automatic t_tick();
      wr(8'h00, 32'h0040_0081);
      rd(8'h08, a, ca);
      rd(8'h08, b, cb);
      `CHK("tick count", 32'(cb - ca), b - a)
      wr(8'h08, 32'h0);
      rd(8'h0C, a, ca);
      `CHK("tick high", 32'h0, a)
      wr(8'h00, 32'h0);
      $display("t_tick done");
   endtask : t_tick

   task automatic t_insert();
      wr(8'h10, 32'h0040_03C2);
      wr(8'h14, 32'h0000_4004);
      wr(8'h18, 32'h0);
      repeat (3) u_iops_tc_model.ins(3'd2);
      repeat (2) u_iops_tc_model.ins(3'd5);
      rd(8'h18, a, ca);
      `CHK("inserts", 32'd3, a)
      wr(8'h10, 32'h0040_01C2);
      wr(8'h18, 32'h0);
      u_iops_tc_model.ins(3'd2);
      rd(8'h18, a, ca);
      `CHK("one mask bit", 32'd0, a)
      wr(8'h10, 32'h0);
      $display("t_insert done");
   endtask : t_insert

   task automatic t_occ();
      u_iops_tc_model.occ(64'h0007_6403);
      wr(8'h24, 32'h0000_4000);
      for (int k = 0; k < 2; k++) begin
         wr(8'h20, k ? 32'h0040_FFD5 : 32'h0040_05D5);
         rd(8'h28, a, ca);
         rd(8'h28, b, cb);
         `CHK("occupancy", 32'((cb - ca) * (k ? 110 : 10)), b - a)
      end
      u_iops_tc_model.occ(64'h0);
      wr(8'h20, 32'h0);
      $display("t_occ done");
   endtask : t_occ

   task automatic t_dreq();
      logic [7:0] um [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
      int ex [5] = '{1056, 8, 9, 9, 6};
      logic [18:0] rq [9] = '{{4'h8, 4'h4, 11'd16}, {4'hC, 4'h4, 11'd8},
         {4'hD, 4'h4, 11'd5}, {4'h4, 4'h4, 11'd9}, {4'h8, 4'h3, 11'd7},
         {4'h8, 4'h4, 11'd1500}, {4'h8, 4'h8, 11'd2}, {4'h8, 4'h9, 11'd3},
         {4'hA, 4'h4, 11'd6}};
      wr(8'h34, 32'h0000_7210);
      for (int k = 0; k < 5; k++) begin
         wr(8'h30, {16'h0040, um[k], 8'hC0});
         wr(8'h38, 32'h0);
         for (int j = 0; j < 9; j++) u_iops_tc_model.req(rq[j]);
         rd(8'h38, a, ca);
         `CHK("dwords", 32'(ex[k]), a)
      end
      wr(8'h30, 32'h0);
      $display("t_dreq done");
   endtask : t_dreq

   // reset, then every scenario in turn
   initial begin
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      t_regs();
      t_restrict();
      t_tick();
      t_insert();
      t_occ();
      t_dreq();
      give_verdict();
   end
endmodule : io_stack_perf_event_select_test
